// ### design/sws_defs.svh
// Constants of the switch status serial slave: widths, bit positions,
// times and derived cycle counts.
// Assumes a single 50 MHz system clock.
//
// Contract
// - Select fall: drive output, capture status word
// - Select rise: output back to high impedance
// - Select rise releases interrupt unless new change
// - Command acts at select rise, tracking resumes
// - Select fall wakes device from sleep
// - Serial input sampled on clock falling edge
// - Output advances on rising, host samples falling
// - Select high: ignore clock, input; tri-state
// - High input bit becomes one in command
// - Open switch reads zero, closed reads one
// - First rising edge presents status bit 24; code presents bit 23, the MSB
// - Both words MSB first through one register
// - Wetting pulse nominal 16 ms, 15 to 20
// - Sleep scan window nominal 200 us
// - Calibrated scan timer within 10 percent
// - Calibrated interrupt timer within 10 percent
// - Status carries switches, interrupt and thermal flags
`ifndef SWS_DEFS_SVH
`define SWS_DEFS_SVH

`define SWS_WORD_BITS   24
`define SWS_SW_NUM      22
`define SWS_ST_INT      23
`define SWS_ST_THERM    22
`define SWS_CNT_W       5
`define SWS_CNT_FULL    5'h18
`define SWS_CNT_MAX     5'h1f
`define SWS_TMR_W       22

`define SWS_CLK_MHZ     50
`define SWS_WET_US      16000
`define SWS_SCAN_US     200
`define SWS_SCAN_PER_US 64000
`define SWS_INT_TMR_US  32000
`define SWS_US2CYC(us)  ((us) * `SWS_CLK_MHZ)

`endif

// ### design/sws_pkg.sv
// Types shared by the switch status serial slave.
// Assumes sws_defs.svh is on the include path.
`include "sws_defs.svh"

package sws_pkg;
   typedef logic [`SWS_WORD_BITS-1:0] sws_word_t;
   typedef logic [`SWS_SW_NUM-1:0]    sws_sw_t;
   typedef logic [`SWS_TMR_W-1:0]     sws_tmr_t;
   typedef logic [`SWS_CNT_W-1:0]     sws_cnt_t;
   typedef enum logic {LNK_IDLE, LNK_SEL} sws_link_e;
endpackage

// ### design/sws_sync.sv
// Two-stage synchroniser, one generate branch per bit.
// Assumes inputs are asynchronous to clk and idle low at reset.
`timescale 1ns/1ps
`default_nettype none

module sws_sync #(
   parameter int W = 1
)(
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               meta <= 1'b0;
               q[i] <= 1'b0;
            end else begin
               meta <= d[i];
               q[i] <= meta;
            end
         end
      end
   endgenerate
endmodule

`default_nettype wire

// ### design/sws_timer.sv
// Restartable one-shot timer: busy for CYC cycles, done pulse at end.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sws_defs.svh"

module sws_timer import sws_pkg::*; #(
   parameter int CYC = 16
)(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic start,
   input  wire logic stop,
   output logic      busy,
   output logic      done
);
   sws_tmr_t cnt;
   sws_tmr_t next_cnt;
   logic     next_busy;
   logic     next_done;
   sws_tmr_t len;

   always_comb begin
      next_cnt  = cnt;
      next_busy = busy;
      next_done = 1'b0;
      if (start) begin
         next_cnt  = `SWS_TMR_W'(CYC - 1);
         next_busy = 1'b1;
      end else if (stop) begin
         next_cnt  = '0;
         next_busy = 1'b0;
      end else if (busy) begin
         if (cnt == '0) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end else begin
            next_cnt = cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt  <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         busy <= next_busy;
         done <= next_done;
      end
   end

   // Helper: busy cycles seen since the last start
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         len <= '0;
      end else if (start) begin
         len <= '0;
      end else if (busy) begin
         len <= len + 1'b1;
      end
   end

   property p_tmr_len;
      @(posedge clk) disable iff (!resetn)
      $fell(busy) && !$past(stop) |-> len == `SWS_TMR_W'(CYC);
   endproperty
   a_tmr_len: assert property (p_tmr_len)
      else $error("timer window length wrong");

   property p_tmr_done;
      @(posedge clk) disable iff (!resetn)
      $fell(busy) && !$past(stop) |-> done ##1 !done;
   endproperty
   a_tmr_done: assert property (p_tmr_done)
      else $error("timer done not a single pulse at end");
endmodule

`default_nettype wire

// ### design/sws_spi_slave.sv
// Serial slave port of a switch detection device with interrupt,
// wetting pulse, sleep scan and wake logic.
// Assumes select, serial clock, serial input and switches are
// asynchronous pins; serial clock much slower than clk.
`timescale 1ns/1ps
`default_nettype none
`include "sws_defs.svh"

module sws_spi_slave import sws_pkg::*; #(
   parameter int WET_CYC      = `SWS_US2CYC(`SWS_WET_US),
   parameter int SCAN_CYC     = `SWS_US2CYC(`SWS_SCAN_US),
   parameter int SCAN_PER_CYC = `SWS_US2CYC(`SWS_SCAN_PER_US),
   parameter int INT_TMR_CYC  = `SWS_US2CYC(`SWS_INT_TMR_US)
)(
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire logic                   cs_n,
   input  wire logic                   sclk,
   input  wire logic                   si,
   input  wire logic [`SWS_SW_NUM-1:0] sw_in,
   input  wire logic                   therm,
   input  wire logic                   sleep_req,
   output logic                        so,
   output logic                        so_oe,
   output logic                        int_out,
   output logic                        int_oe,
   output logic [`SWS_WORD_BITS-1:0]   cmd_word,
   output logic                        cmd_valid,
   output logic                        awake,
   output logic                        wet_on,
   output logic                        scan_on
);
   localparam int SYN_W = `SWS_SW_NUM + 4;

   logic [SYN_W-1:0] syn_q;
   sws_sw_t   sw_s;
   logic      therm_s;
   logic      si_s;
   logic      sclk_s;
   logic      cs_s;
   logic      cs_d;
   logic      sclk_d;
   logic      cs_fall;
   logic      cs_rise;
   logic      sclk_rise;
   logic      sclk_fall;

   sws_link_e st;
   sws_link_e next_st;
   sws_word_t shreg;
   sws_word_t next_shreg;
   sws_cnt_t  cnt;
   sws_cnt_t  next_cnt;
   logic      next_so;
   logic      next_so_oe;
   sws_word_t next_cmd_word;
   logic      next_cmd_valid;
   sws_word_t status;

   sws_sw_t   sw_prev;
   sws_sw_t   next_sw_prev;
   logic      int_pend;
   logic      next_int_pend;
   logic      chg_low;
   logic      next_chg_low;
   logic      next_awake;
   logic      sampling;
   logic      chg;

   logic      wet_busy;
   logic      scan_busy;
   logic      scan_done;
   logic      per_busy;
   logic      per_done;
   logic      itmr_done;
   logic      wet_start;
   logic      per_start;
   logic      itmr_start;

   // Select is inverted before the synchroniser so that it idles low
   sws_sync #(
      .W      (SYN_W)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({sw_in, therm, si, sclk, ~cs_n}),
      .q      (syn_q)
   );

   assign cs_s    = syn_q[0];
   assign sclk_s  = syn_q[1];
   assign si_s    = syn_q[2];
   assign therm_s = syn_q[3];
   assign sw_s    = syn_q[SYN_W-1:4];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs_d   <= 1'b0;
         sclk_d <= 1'b0;
      end else begin
         cs_d   <= cs_s;
         sclk_d <= sclk_s;
      end
   end

   assign cs_fall   = cs_s & ~cs_d;
   assign cs_rise   = ~cs_s & cs_d;
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;

   // Closed switch reads one; polarity is resolved ahead of this block
   assign status = {int_pend, therm_s, sw_s};

   // Link: one shift register carries status out and command in
   always_comb begin
      next_st        = st;
      next_shreg     = shreg;
      next_cnt       = cnt;
      next_so        = so;
      next_so_oe     = so_oe;
      next_cmd_word  = cmd_word;
      next_cmd_valid = 1'b0;
      unique case (st)
         LNK_IDLE: begin
            // Serial clock and input are not looked at here
            if (cs_fall) begin
               next_st    = LNK_SEL;
               next_shreg = status;
               next_cnt   = '0;
               next_so    = 1'b0;
               next_so_oe = 1'b1;
            end
         end
         LNK_SEL: begin
            if (cs_rise) begin
               next_st    = LNK_IDLE;
               next_so    = 1'b0;
               next_so_oe = 1'b0;
               // Partial words are dropped rather than executed
               if (cnt == `SWS_CNT_FULL) begin
                  next_cmd_word  = shreg;
                  next_cmd_valid = 1'b1;
               end
            end else if (sclk_rise) begin
               next_so = shreg[`SWS_WORD_BITS-1];
            end else if (sclk_fall) begin
               next_shreg = {shreg[`SWS_WORD_BITS-2:0], si_s};
               if (cnt != `SWS_CNT_MAX) begin
                  next_cnt = cnt + 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st        <= LNK_IDLE;
         shreg     <= '0;
         cnt       <= '0;
         so        <= 1'b0;
         so_oe     <= 1'b0;
         cmd_word  <= '0;
         cmd_valid <= 1'b0;
      end else begin
         st        <= next_st;
         shreg     <= next_shreg;
         cnt       <= next_cnt;
         so        <= next_so;
         so_oe     <= next_so_oe;
         cmd_word  <= next_cmd_word;
         cmd_valid <= next_cmd_valid;
      end
   end

   // Switches are only meaningful while awake or inside a scan window
   assign sampling = awake | scan_busy;
   assign chg      = sampling & (|(sw_s ^ sw_prev));

   // Interrupt, change tracking and power state
   always_comb begin
      next_sw_prev  = sw_prev;
      next_int_pend = int_pend;
      next_chg_low  = chg_low;
      next_awake    = awake;
      if (sampling) begin
         next_sw_prev = sw_s;
      end
      if (cs_fall) begin
         next_chg_low = 1'b0;
      end else if (chg && st == LNK_SEL) begin
         next_chg_low = 1'b1;
      end
      if (cs_rise && !chg_low) begin
         next_int_pend = 1'b0;
      end
      // Set wins over the release in the same cycle
      if (chg) begin
         next_int_pend = 1'b1;
      end
      if (sleep_req && st == LNK_IDLE) begin
         next_awake = 1'b0;
      end
      // Status of a waking transfer may be stale; host must discard it
      if (cs_fall || itmr_done || chg) begin
         next_awake = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sw_prev  <= '0;
         int_pend <= 1'b0;
         chg_low  <= 1'b0;
         awake    <= 1'b1;
         int_out  <= 1'b0;
         int_oe   <= 1'b0;
         wet_on   <= 1'b0;
         scan_on  <= 1'b0;
      end else begin
         sw_prev  <= next_sw_prev;
         int_pend <= next_int_pend;
         chg_low  <= next_chg_low;
         awake    <= next_awake;
         int_out  <= 1'b0;
         int_oe   <= next_int_pend;
         wet_on   <= wet_busy;
         scan_on  <= scan_busy;
      end
   end

   assign wet_start  = chg & awake;
   assign per_start  = ~awake & ~per_busy & ~scan_busy;
   assign itmr_start = awake & sleep_req & (st == LNK_IDLE);

   // Wetting pulse restarts on every change while awake
   sws_timer #(
      .CYC    (WET_CYC)
   ) u_wet (
      .clk    (clk),
      .resetn (resetn),
      .start  (wet_start),
      .stop   (1'b0),
      .busy   (wet_busy),
      .done   ()
   );

   // Scan period, counted exactly so calibration error stays in range
   sws_timer #(
      .CYC    (SCAN_PER_CYC)
   ) u_per (
      .clk    (clk),
      .resetn (resetn),
      .start  (per_start),
      .stop   (awake),
      .busy   (per_busy),
      .done   (per_done)
   );

   sws_timer #(
      .CYC    (SCAN_CYC)
   ) u_scan (
      .clk    (clk),
      .resetn (resetn),
      .start  (per_done),
      .stop   (awake),
      .busy   (scan_busy),
      .done   ()
   );

   sws_timer #(
      .CYC    (INT_TMR_CYC)
   ) u_itmr (
      .clk    (clk),
      .resetn (resetn),
      .start  (itmr_start),
      .stop   (cs_fall),
      .busy   (),
      .done   (itmr_done)
   );

   property p_so_en;
      @(posedge clk) disable iff (!resetn)
      cs_fall && st == LNK_IDLE |=> so_oe && !so;
   endproperty
   a_so_en: assert property (p_so_en)
      else $error("output not enabled after select fall");

   property p_capture;
      @(posedge clk) disable iff (!resetn)
      cs_fall && st == LNK_IDLE |=> shreg == $past(status);
   endproperty
   a_capture: assert property (p_capture)
      else $error("status word not captured at select fall");

   property p_so_off;
      @(posedge clk) disable iff (!resetn)
      cs_rise |=> !so_oe ##1 !so_oe;
   endproperty
   a_so_off: assert property (p_so_off)
      else $error("output still driven after select rise");

   property p_int_rel;
      @(posedge clk) disable iff (!resetn)
      cs_rise && !chg_low && !chg |=> !int_pend && !int_oe;
   endproperty
   a_int_rel: assert property (p_int_rel)
      else $error("interrupt not released at select rise");

   property p_int_hold;
      @(posedge clk) disable iff (!resetn)
      cs_rise && chg_low |=> int_pend ##1 int_oe;
   endproperty
   a_int_hold: assert property (p_int_hold)
      else $error("interrupt released despite change during select");

   property p_cmd;
      @(posedge clk) disable iff (!resetn)
      cs_rise && st == LNK_SEL && cnt == `SWS_CNT_FULL
         |=> cmd_valid && cmd_word == $past(shreg) ##1 !cmd_valid;
   endproperty
   a_cmd: assert property (p_cmd)
      else $error("full word not committed at select rise");

   property p_discard;
      @(posedge clk) disable iff (!resetn)
      cs_rise && cnt != `SWS_CNT_FULL |=> !cmd_valid && $stable(cmd_word);
   endproperty
   a_discard: assert property (p_discard)
      else $error("partial word was committed");

   property p_wake;
      @(posedge clk) disable iff (!resetn)
      cs_fall && !awake |=> awake;
   endproperty
   a_wake: assert property (p_wake)
      else $error("select fall did not wake");

   property p_shift_in;
      @(posedge clk) disable iff (!resetn)
      st == LNK_SEL && sclk_fall && !cs_rise
         |=> shreg[0] == $past(si_s)
             && shreg[`SWS_WORD_BITS-1:1] == $past(shreg[`SWS_WORD_BITS-2:0]);
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("input bit not shifted in on clock fall");

   property p_shift_out;
      @(posedge clk) disable iff (!resetn)
      st == LNK_SEL && sclk_rise && !cs_rise
         |=> so == $past(shreg[`SWS_WORD_BITS-1]);
   endproperty
   a_shift_out: assert property (p_shift_out)
      else $error("output bit not advanced on clock rise");

   property p_ignore;
      @(posedge clk) disable iff (!resetn)
      st == LNK_IDLE && !cs_fall |=> $stable(shreg) && !so_oe;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("activity while deselected changed the port");
endmodule

`default_nettype wire

// ### test/sws_host.sv
// Host side of the switch status port: a serial bus master model.
// Assumes clk is the bench clock; pins move only at falling clk edges.
`timescale 1ns/1ps
`default_nettype none

module sws_host (
   input  wire logic clk,
   input  wire logic so,
   input  wire logic so_oe,
   output logic      cs_n,
   output logic      sclk,
   output logic      si
);
   // Four clk per phase gives the 160 ns link period
   localparam int HALF = 4;

   // Undriven output reads as high impedance (z), so a missing enable is caught
   wire logic so_pin = so_oe ? so : 1'bz;

   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end

   task automatic xfer(input logic [47:0] tx, input int n,
                       output logic [47:0] rx);
      rx = '0;
      @(negedge clk);
      cs_n = 1'b0;
      repeat (HALF) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         si   = tx[n-1-i];
         sclk = 1'b1;
         repeat (HALF) @(negedge clk);
         rx   = {rx[46:0], so_pin};
         sclk = 1'b0;
         repeat (HALF) @(negedge clk);
      end
      // Released data line must not keep its last bit
      si   = ~si;
      cs_n = 1'b1;
      repeat (2 * HALF) @(negedge clk);
   endtask

   // Clock and data wiggle while deselected
   task automatic idle_noise(input int n);
      for (int i = 0; i < n; i++) begin
         sclk = ~sclk;
         si   = ~si;
         repeat (HALF) @(negedge clk);
      end
      sclk = 1'b0;
   endtask
endmodule

`default_nettype wire

// ### test/sws_spi_slave_bench.sv
// Self-checking bench for the switch status serial slave.
// Assumes sws_pkg is compiled first; short timer parameters are used.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) \
   begin \
      samples_checked++; \
      if ((a) !== (b)) begin \
         failures++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); \
      end \
   end

module sws_spi_slave_bench import sws_pkg::*;;
   localparam int WET  = 40;
   localparam int SCAN = 10;
   localparam int SCAN_PER = 50;
   localparam int INT_TMR  = 200;

   logic        clk = 1'b0;
   logic        resetn;
   sws_sw_t     sw_in;
   logic        therm;
   logic        sleep_req;
   wire logic   cs_n;
   wire logic   sclk;
   wire logic   si;
   logic        so;
   logic        so_oe;
   logic        int_out;
   logic        int_oe;
   sws_word_t   cmd_word;
   logic        cmd_valid;
   logic        awake;
   logic        wet_on;
   logic        scan_on;
   int unsigned valid_cnt = 0;
   int          failures = 0;
   int          samples_checked = 0;

   // Open drain interrupt with pull-up
   wire logic int_n = int_oe ? int_out : 1'b1;

   always #10 clk = ~clk;

   always @(posedge clk) begin
      if (cmd_valid === 1'b1) begin
         valid_cnt <= valid_cnt + 1;
      end
   end

   sws_spi_slave #(.WET_CYC(WET), .SCAN_CYC(SCAN), .SCAN_PER_CYC(SCAN_PER),
                   .INT_TMR_CYC(INT_TMR)) sws_spi_slave_inst (
      .clk       (clk),
      .resetn    (resetn),
      .cs_n      (cs_n),
      .sclk      (sclk),
      .si        (si),
      .sw_in     (sw_in),
      .therm     (therm),
      .sleep_req (sleep_req),
      .so        (so),
      .so_oe     (so_oe),
      .int_out   (int_out),
      .int_oe    (int_oe),
      .cmd_word  (cmd_word),
      .cmd_valid (cmd_valid),
      .awake     (awake),
      .wet_on    (wet_on),
      .scan_on   (scan_on)
   );

   sws_host sws_host_inst (
      .clk   (clk),
      .so    (so),
      .so_oe (so_oe),
      .cs_n  (cs_n),
      .sclk  (sclk),
      .si    (si)
   );

   task automatic end_sim();
      $display("checked=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic t_reset();
      `CHK(so_oe, 1'b0)
      `CHK(int_n, 1'b1)
      `CHK(cmd_word, 24'h000000)
      `CHK(awake, 1'b1)
      $display("reset values done");
   endtask

   task automatic t_frame();
      logic [47:0] rx;
      int          n;
      int unsigned vc;
      sw_in = 22'h2a5c3d;
      therm = 1'b1;
      n = 0;
      while (n < 20 && int_n !== 1'b0) begin
         n++;
         @(negedge clk);
      end
      `CHK(int_n, 1'b0)
      n = 0;
      while (n < 5 && wet_on !== 1'b1) begin
         n++;
         @(negedge clk);
      end
      `CHK(wet_on, 1'b1)
      n = 0;
      while (n < 100 && wet_on === 1'b1) begin
         n++;
         @(negedge clk);
      end
      `CHK(n, WET)
      vc = valid_cnt;
      fork
         sws_host_inst.xfer({24'h000000, 24'hc3a5f1}, 24, rx);
         begin
            repeat (10) @(negedge clk);
            `CHK(so_oe, 1'b1)
         end
      join
      `CHK(rx[23:0], {2'b11, 22'h2a5c3d})
      `CHK(cmd_word, 24'hc3a5f1)
      `CHK(valid_cnt, vc + 1)
      `CHK(int_n, 1'b1)
      `CHK(so_oe, 1'b0)
      $display("frame test done");
   endtask

   task automatic t_int_hold();
      logic [47:0] rx;
      fork
         sws_host_inst.xfer({24'h000000, 24'h5a0f33}, 24, rx);
         begin
            repeat (60) @(negedge clk);
            sw_in = 22'h15a3c2;
         end
      join
      `CHK(rx[23:0], {2'b01, 22'h2a5c3d})
      `CHK(int_n, 1'b0)
      sws_host_inst.xfer({24'h000000, 24'h0f0f0f}, 24, rx);
      `CHK(rx[23:0], {2'b11, 22'h15a3c2})
      `CHK(int_n, 1'b1)
      $display("interrupt hold test done");
   endtask

   task automatic t_discard();
      logic [47:0] rx;
      int unsigned vc;
      vc = valid_cnt;
      sws_host_inst.xfer(48'h9ce17b_00ff11, 48, rx);
      `CHK(rx[23:0], 24'h9ce17b)
      `CHK(rx[47:24], {2'b01, 22'h15a3c2})
      `CHK(valid_cnt, vc)
      `CHK(cmd_word, 24'h0f0f0f)
      sws_host_inst.xfer(48'h000000_0abcde, 20, rx);
      `CHK(valid_cnt, vc)
      `CHK(cmd_word, 24'h0f0f0f)
      sws_host_inst.idle_noise(16);
      `CHK(so_oe, 1'b0)
      `CHK(valid_cnt, vc)
      $display("discard test done");
   endtask

   task automatic t_sleep();
      logic [47:0] rx;
      int          n;
      sleep_req = 1'b1;
      @(negedge clk);
      sleep_req = 1'b0;
      @(negedge clk);
      `CHK(awake, 1'b0)
      n = 0;
      while (n < 200 && scan_on !== 1'b1) begin
         n++;
         @(negedge clk);
      end
      `CHK(scan_on, 1'b1)
      n = 0;
      while (n < 100 && scan_on === 1'b1) begin
         n++;
         @(negedge clk);
      end
      `CHK(n, SCAN)
      // Status of a waking transfer is not trusted
      fork
         sws_host_inst.xfer({24'h000000, 24'h123456}, 24, rx);
         begin
            repeat (10) @(negedge clk);
            `CHK(awake, 1'b1)
         end
      join
      $display("sleep wake test done");
   endtask

   // Timers measured in sleep with no select, within 10 percent
   task automatic t_sleep_timer();
      int n;
      int n_scan;
      sleep_req = 1'b1;
      @(negedge clk);
      sleep_req = 1'b0;
      n = 1;
      while (n < 300 && scan_on !== 1'b1) begin
         n++;
         @(negedge clk);
      end
      n_scan = n;
      while (n < 300 && scan_on === 1'b1) begin
         n++;
         @(negedge clk);
      end
      while (n < 300 && scan_on !== 1'b1) begin
         n++;
         @(negedge clk);
      end
      `CHK((n - n_scan) * 10 >= SCAN_PER * 9 && (n - n_scan) * 10 <= SCAN_PER * 11, 1'b1)
      while (n < 300 && awake !== 1'b1) begin
         n++;
         @(negedge clk);
      end
      `CHK(n * 10 >= INT_TMR * 9 && n * 10 <= INT_TMR * 11, 1'b1)
      $display("sleep timer test done");
   endtask

   initial begin
      resetn    = 1'b0;
      sw_in     = '0;
      therm     = 1'b0;
      sleep_req = 1'b0;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_frame();
      t_int_hold();
      t_discard();
      t_sleep();
      t_sleep_timer();
      end_sim();
   end
endmodule

`default_nettype wire
